// file: pkg/srm_pkg.sv
package srm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned SCL_QUARTER_NS = 2500;
    localparam logic [15:0] QUARTER_CYC    =
        16'((SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////////
    // Image layout and serial framing
    localparam logic [4:0] SHORT_LEN   = 5'h0c;
    localparam logic [4:0] LONG_LEN    = 5'h17;
    localparam logic [2:0] LONG_SEL    = 3'h2;
    localparam logic [6:0] SEL_CODE    = 7'h50;
    localparam logic [7:0] EE_START_AD = 8'h00;
    localparam logic [1:0] TX_SELW     = 2'h0;
    localparam logic [1:0] TX_ADDR     = 2'h1;
    localparam logic [1:0] TX_SELR     = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_SUBSYS  = 8'h00;
    localparam logic [7:0] OFS_ROMCTL  = 8'h04;
    localparam logic [7:0] OFS_T0CTL   = 8'h08;
    localparam logic [7:0] OFS_T1CTL   = 8'h0c;
    localparam logic [7:0] OFS_LS0CTL  = 8'h10;
    localparam logic [7:0] OFS_LS0AT   = 8'h14;
    localparam logic [7:0] OFS_IDENT   = 8'h18;
    localparam logic [7:0] OFS_CLASS   = 8'h1c;
    localparam logic [7:0] OFS_MISC    = 8'h20;
    localparam logic [7:0] OFS_STATUS  = 8'h24;
    localparam logic [7:0] OFS_DIV     = 8'h28;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values; identity default is arbitrary
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [31:0] RST_IDENT  = 32'h1234_5678;
    localparam logic [23:0] RST_CLASS  = 24'h06_80_00;
    localparam logic [7:0]  RST_LAT    = 8'h00;

    typedef struct packed {
        logic [31:0] subsystem_ident_reg;
        logic [31:0] rom_window_control;
        logic [31:0] target0_control;
        logic [31:0] target1_control;
        logic [31:0] local_slave0_control;
        logic [31:0] local_slave0_translation;
        logic [31:0] ident_reg;
        logic [23:0] class_code;
        logic [7:0]  latency_limit;
    } srm_cfg_t;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_STOPA = 6'h02,
        ST_START = 6'h04,
        ST_TX    = 6'h08,
        ST_RX    = 6'h10,
        ST_STOPZ = 6'h20
    } srm_state_t;

endpackage

// file: src/srm_loader.sv
module srm_loader
    import srm_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Host bus side
    input  wire logic              host_rst_n,
    input  wire logic              load_enable_pin,
    output logic                   host_retry,
    output srm_cfg_t               cfg,
    // Serial EEPROM
    output logic                   scl_out,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe
);

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers and reset strap
    logic [1:0] sda_s_ff, load_enable_pin_s_ff, hrst_s_ff;
    logic       hrst_q_ff, strap_ff, start_load;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_s_ff  <= 2'h3;
            load_enable_pin_s_ff <= 2'h0;
            hrst_s_ff <= 2'h0;
            hrst_q_ff <= 1'b0;
        end else begin
            sda_s_ff  <= {sda_s_ff[0], sda_in};
            load_enable_pin_s_ff <= {load_enable_pin_s_ff[0], load_enable_pin};
            hrst_s_ff <= {hrst_s_ff[0], host_rst_n};
            hrst_q_ff <= hrst_s_ff[1];
        end
    end

    // Strap caught while host reset is held, used at its release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_ff <= 1'b0;
        end else if (!hrst_s_ff[1]) begin
            strap_ff <= sda_s_ff[1] | load_enable_pin_s_ff[1];
        end
    end

    assign start_load = hrst_s_ff[1] & ~hrst_q_ff & strap_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Quarter-bit timebase
    logic [15:0] div_ff, cnt_ff;
    logic [1:0]  qtr_ff;
    logic        tick, bit_end;
    srm_state_t  state_ff;

    assign tick    = (cnt_ff >= div_ff - 16'h0001);
    assign bit_end = tick & (qtr_ff == 2'h3);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 16'h0000;
            qtr_ff <= 2'h0;
        end else if (state_ff == ST_IDLE || tick) begin
            cnt_ff <= 16'h0000;
            qtr_ff <= (state_ff == ST_IDLE) ? 2'h0 : qtr_ff + 2'h1;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Serial sequencer
    logic [3:0] bit_ff;
    logic [7:0] tx_sh_ff, rx_sh_ff;
    logic [1:0] tx_idx_ff;
    logic [4:0] byte_idx_ff;
    logic       nack_ff, loading_ff, done_ff, err_ff, long_ff;
    logic       more, load_byte;

    // Ack byte 11 only if its selector asks for the long image
    assign more = (byte_idx_ff < SHORT_LEN - 5'h01) ||
                  (byte_idx_ff == SHORT_LEN - 5'h01 && rx_sh_ff[2:0] == LONG_SEL) ||
                  (byte_idx_ff > SHORT_LEN - 5'h01 && byte_idx_ff < LONG_LEN - 5'h01);
    assign load_byte = (state_ff == ST_RX) & bit_end & (bit_ff == 4'h8);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff    <= ST_IDLE;
            bit_ff      <= 4'h0;
            tx_sh_ff    <= 8'h00;
            rx_sh_ff    <= 8'h00;
            tx_idx_ff   <= TX_SELW;
            byte_idx_ff <= 5'h00;
            nack_ff     <= 1'b0;
            loading_ff  <= 1'b0;
            done_ff     <= 1'b0;
            err_ff      <= 1'b0;
            long_ff     <= 1'b0;
        end else if (!hrst_s_ff[1]) begin
            // Host reset mid-load abandons the image
            state_ff   <= ST_IDLE;
            loading_ff <= 1'b0;
        end else if (state_ff == ST_IDLE) begin
            if (start_load) begin
                state_ff    <= ST_STOPA;
                loading_ff  <= 1'b1;
                done_ff     <= 1'b0;
                err_ff      <= 1'b0;
                long_ff     <= 1'b0;
                tx_idx_ff   <= TX_SELW;
                byte_idx_ff <= 5'h00;
            end
        end else begin
            if (tick && qtr_ff == 2'h2) begin
                if (state_ff == ST_TX && bit_ff == 4'h8) begin
                    nack_ff <= sda_s_ff[1];
                end
                if (state_ff == ST_RX && bit_ff < 4'h8) begin
                    rx_sh_ff <= {rx_sh_ff[6:0], sda_s_ff[1]};
                end
            end
            if (bit_end) begin
                bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
                unique case (state_ff)
                    ST_STOPA: begin
                        state_ff <= ST_START;
                    end
                    ST_START: begin
                        state_ff <= ST_TX;
                        bit_ff   <= 4'h0;
                        tx_sh_ff <= {SEL_CODE, tx_idx_ff == TX_SELR};
                    end
                    ST_TX: begin
                        if (bit_ff < 4'h8) begin
                            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                        end else if (nack_ff) begin
                            err_ff   <= 1'b1;
                            state_ff <= ST_STOPZ;
                        end else if (tx_idx_ff == TX_SELW) begin
                            tx_idx_ff <= TX_ADDR;
                            tx_sh_ff  <= EE_START_AD;
                        end else if (tx_idx_ff == TX_ADDR) begin
                            tx_idx_ff <= TX_SELR;
                            state_ff  <= ST_START;
                        end else begin
                            state_ff <= ST_RX;
                        end
                    end
                    ST_RX: begin
                        if (bit_ff == 4'h8) begin
                            byte_idx_ff <= byte_idx_ff + 5'h01;
                            if (byte_idx_ff == SHORT_LEN - 5'h01) begin
                                long_ff <= (rx_sh_ff[2:0] == LONG_SEL);
                            end
                            if (!more) begin
                                state_ff <= ST_STOPZ;
                            end
                        end
                    end
                    ST_STOPZ: begin
                        state_ff   <= ST_IDLE;
                        loading_ff <= 1'b0;
                        done_ff    <= 1'b1;
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Line levels, registered so pins never glitch
    logic nxt_scl, nxt_sda, scl_ff, sda_oe_ff;

    always_comb begin
        nxt_scl = (qtr_ff == 2'h1) || (qtr_ff == 2'h2);
        nxt_sda = 1'b1;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_scl = 1'b1;
            end
            ST_STOPA, ST_STOPZ: begin
                nxt_scl = (qtr_ff != 2'h0);
                nxt_sda = qtr_ff[1];
            end
            ST_START: begin
                nxt_sda = ~qtr_ff[1];
            end
            ST_TX: begin
                nxt_sda = (bit_ff < 4'h8) ? tx_sh_ff[7] : 1'b1;
            end
            ST_RX: begin
                nxt_sda = (bit_ff < 4'h8) ? 1'b1 : ~more;
            end
            default: begin
                nxt_scl = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_ff    <= 1'b1;
            sda_oe_ff <= 1'b0;
        end else begin
            scl_ff    <= nxt_scl;
            sda_oe_ff <= ~nxt_sda;
        end
    end

    assign scl_out    = scl_ff;
    assign sda_out    = 1'b0;
    assign sda_oe     = sda_oe_ff;
    assign host_retry = loading_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration image
    srm_cfg_t   cfg_ff;
    logic       rom_en_ff;
    logic [7:0] b;
    logic       wr_acc, rd_setup;
    logic [7:0] ofs;

    assign b        = rx_sh_ff;
    assign ofs      = 8'(paddr);
    assign wr_acc   = psel & penable & pwrite & ~loading_ff;
    assign rd_setup = psel & ~penable & ~pwrite;

    // ROM gate spans bytes 4 to 7; target gates act within their own byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rom_en_ff <= 1'b0;
        end else if (start_load) begin
            rom_en_ff <= 1'b0;
        end else if (load_byte && byte_idx_ff == 5'h04) begin
            rom_en_ff <= b[7];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= '{RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD,
                        RST_IDENT, RST_CLASS, RST_LAT};
        end else if (load_byte) begin
            unique case (byte_idx_ff)
                5'h00: cfg_ff.subsystem_ident_reg[31:24] <= b;
                5'h01: cfg_ff.subsystem_ident_reg[23:16] <= b;
                5'h02: cfg_ff.subsystem_ident_reg[15:8]  <= b;
                5'h03: cfg_ff.subsystem_ident_reg[7:0]   <= b;
                5'h04: if (b[7]) cfg_ff.rom_window_control[22:16] <= b[6:0];
                5'h05: if (rom_en_ff) cfg_ff.rom_window_control[15:8] <= b;
                5'h06: if (rom_en_ff) cfg_ff.rom_window_control[7:0]  <= b;
                5'h07: begin
                    if (rom_en_ff) cfg_ff.rom_window_control[25:24] <= b[7:6];
                    if (b[5]) begin
                        cfg_ff.target0_control[27:24] <= b[4:1];
                        cfg_ff.target0_control[6]     <= b[0];
                    end
                end
                5'h08: begin
                    if (b[7]) begin
                        cfg_ff.target1_control[27:24] <= b[6:3];
                        cfg_ff.target1_control[6]     <= b[2];
                    end
                    cfg_ff.local_slave0_control[31] <= b[1];
                    cfg_ff.local_slave0_control[24] <= b[0];
                end
                5'h09: cfg_ff.local_slave0_translation[31:24] <= b;
                5'h0a: cfg_ff.local_slave0_translation[23:16] <= b;
                5'h0b: begin
                    cfg_ff.local_slave0_translation[7:4] <= b[7:4];
                    cfg_ff.local_slave0_translation[1]   <= b[3];
                end
                5'h0c: cfg_ff.ident_reg[31:24] <= b;
                5'h0d: cfg_ff.ident_reg[23:16] <= b;
                5'h0e: cfg_ff.ident_reg[15:8]  <= b;
                5'h0f: cfg_ff.ident_reg[7:0]   <= b;
                5'h10: cfg_ff.class_code[23:16] <= b;
                5'h11: cfg_ff.class_code[15:8]  <= b;
                5'h12: cfg_ff.class_code[7:0]   <= b;
                5'h13: cfg_ff.latency_limit     <= b;
                default: begin
                end
            endcase
        end else if (wr_acc) begin
            unique case (ofs)
                OFS_SUBSYS: cfg_ff.subsystem_ident_reg      <= pwdata;
                OFS_ROMCTL: cfg_ff.rom_window_control       <= pwdata;
                OFS_T0CTL:  cfg_ff.target0_control          <= pwdata;
                OFS_T1CTL:  cfg_ff.target1_control          <= pwdata;
                OFS_LS0CTL: cfg_ff.local_slave0_control     <= pwdata;
                OFS_LS0AT:  cfg_ff.local_slave0_translation <= pwdata;
                OFS_IDENT:  cfg_ff.ident_reg                <= pwdata;
                OFS_CLASS:  cfg_ff.class_code               <= pwdata[23:0];
                OFS_MISC:   cfg_ff.latency_limit            <= pwdata[31:24];
                default: begin
                end
            endcase
        end
    end

    assign cfg = cfg_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer; read data is captured in setup so it leaves a flop
    logic [31:0] rd_mux;
    logic        hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= QUARTER_CYC;
        end else if (psel && penable && pwrite && ofs == OFS_DIV) begin
            // Zero would wrap to the slowest timebase, 65536 cycles a quarter
            div_ff <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        end
    end

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (ofs)
            OFS_SUBSYS: rd_mux = cfg_ff.subsystem_ident_reg;
            OFS_ROMCTL: rd_mux = cfg_ff.rom_window_control;
            OFS_T0CTL:  rd_mux = cfg_ff.target0_control;
            OFS_T1CTL:  rd_mux = cfg_ff.target1_control;
            OFS_LS0CTL: rd_mux = cfg_ff.local_slave0_control;
            OFS_LS0AT:  rd_mux = cfg_ff.local_slave0_translation;
            OFS_IDENT:  rd_mux = cfg_ff.ident_reg;
            OFS_CLASS:  rd_mux = {8'h00, cfg_ff.class_code};
            OFS_MISC:   rd_mux = {cfg_ff.latency_limit, 24'h000000};
            OFS_STATUS: rd_mux = {28'h0000000, long_ff, err_ff, done_ff, loading_ff};
            OFS_DIV:    rd_mux = {16'h0000, div_ff};
            default:    hit = 1'b0;
        endcase
        if (loading_ff && ofs < OFS_STATUS) begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

endmodule

// file: test/srm_eeprom_model.sv
module srm_eeprom_model (
    // Serial pins
    input  wire logic scl,
    input  wire logic sda,
    output logic      pull
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [1:0] mode;
    logic [1:0] nxt;
    logic       nack;
    int         bitc;
    int         hold_ns;
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        pull = 1'b0;
        mode = 2'h0;
        nxt = 2'h0;
        ptr = 8'h00;
        bitc = 0;
        hold_ns = 2;
    end
    ////////////////////////////////////////
    // Start and stop framing
    always @(negedge sda) if (scl === 1'b1) begin
        mode = 2'h1;
        bitc = 0;
        nack = 1'b0;
    end
    always @(posedge sda) if (scl === 1'b1) mode = 2'h0;
    always @(posedge scl) if (mode != 2'h0) begin
        if (mode != 2'h3 && bitc < 8) sh = {sh[6:0], sda};
        if (mode == 2'h3 && bitc == 8) nack = sda;
        bitc++;
    end
    // Data moves only while the clock is low, late by hold_ns
    always @(negedge scl) if (mode != 2'h0) begin
        #(hold_ns);
        if (bitc == 8) begin
            pull = 1'b0;
            nxt = 2'h0;
            if (mode == 2'h3) ptr++;
            else if (mode == 2'h1 && sh[7:1] == 7'h50) begin
                pull = 1'b1;
                nxt = sh[0] ? 2'h3 : 2'h2;
            end else if (mode == 2'h2) begin
                pull = 1'b1;
                ptr = sh;
            end
        end else if (bitc == 9) begin
            bitc = 0;
            if (mode != 2'h3 || nack) mode = nxt;
            pull = mode == 2'h3 && !mem[ptr][7];
        end else if (mode == 2'h3) pull = !mem[ptr][7-bitc];
    end
endmodule

// file: test/srm_loader_bench.sv
module srm_loader_bench
    import srm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        host_rst_n, load_enable_pin, host_retry, scl_out, sda_oe, ee_pull;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, wv;
    wire logic   sda_line;
    srm_cfg_t    cfg, want;
    logic [7:0]  img [23];
    logic [2:0]  sel_tab [3] = '{3'h0, 3'h2, 3'h5};
    int          fail_count, checks_done;
    srm_loader #(.ADDR_W(8)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_rst_n(host_rst_n), .load_enable_pin(load_enable_pin), .host_retry(host_retry),
        .cfg(cfg), .scl_out(scl_out), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe)
    );
    srm_eeprom_model ee (.scl(scl_out), .sda(sda_line), .pull(ee_pull));
    // Pull-up on the data line
    assign sda_line = !(sda_oe || ee_pull);
    ////////////////////////////////////////
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp_v, input string what);
        checks_done++;
        if (got !== exp_v) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp_v);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_retry(input logic lvl, input int lim);
        int n;
        n = 0;
        while (host_retry !== lvl && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk_val(32'(host_retry), 32'(lvl), "retry level");
    endtask
    function automatic logic [31:0] rst_word(input int a);
        case (a)
            6: return RST_IDENT;
            7: return {8'h00, RST_CLASS};
            8: return {RST_LAT, 24'h0};
            10: return 32'h271;
            default: return RST_WORD;
        endcase
    endfunction
    function automatic srm_cfg_t exp_cfg(input logic [7:0] b [23], input logic lg);
        srm_cfg_t c;
        c.subsystem_ident_reg = {b[0], b[1], b[2], b[3]};
        c.rom_window_control = b[4][7] ? {6'h0, b[7][7:6], 1'b0, b[4][6:0], b[5], b[6]} : 0;
        c.target0_control = b[7][5] ? {4'h0, b[7][4:1], 17'h0, b[7][0], 6'h0} : 0;
        c.target1_control = b[8][7] ? {4'h0, b[8][6:3], 17'h0, b[8][2], 6'h0} : 0;
        c.local_slave0_control = {b[8][1], 6'h0, b[8][0], 24'h0};
        c.local_slave0_translation = {b[9], b[10], 8'h0, b[11][7:4], 2'h0, b[11][3], 1'b0};
        c.ident_reg = lg ? {b[12], b[13], b[14], b[15]} : RST_IDENT;
        c.class_code = lg ? {b[16], b[17], b[18]} : RST_CLASS;
        c.latency_limit = lg ? b[19] : RST_LAT;
        return c;
    endfunction
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Three loads take some 6200 cycles
    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        test_done();
    end
    initial begin
        {presetn, host_rst_n, psel, penable, pwrite, load_enable_pin} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(32'he2021464));
        for (int k = 0; k < 3; k++) begin
            presetn <= 1'b0;
            host_rst_n <= 1'b0;
            repeat (12) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            for (int a = 0; a < 11 && k == 0; a++) begin
                apb(1'b0, 8'(a * 4), 32'h0);
                chk_val(rd, rst_word(a), "reset value");
            end
            apb(1'b0, 8'h2c, 32'h0);
            chk_val(32'(err), 32'h1, "unmapped error");
            apb(1'b1, OFS_DIV, 32'h3);
            foreach (img[i]) img[i] = 8'($urandom);
            img[11][2:0] = sel_tab[k];
            if (k < 2) begin
                {img[4][7], img[7][5], img[8][7]} = {3{k[0]}};
            end
            foreach (img[i]) ee.mem[i] = img[i];
            ee.hold_ns = 1 + 5 * k;
            load_enable_pin <= 1'($urandom);
            host_rst_n <= 1'b1;
            wait_retry(1'b1, 20);
            apb(1'b1, OFS_SUBSYS, $urandom);
            apb(1'b0, OFS_SUBSYS, 32'h0);
            chk_val(rd, 32'h0, "read while loading");
            wait_retry(1'b0, 15000);
            want = exp_cfg(img, sel_tab[k] == 3'h2);
            chk_val(cfg.subsystem_ident_reg, want.subsystem_ident_reg, "subsys");
            chk_val(cfg.rom_window_control, want.rom_window_control, "rom");
            chk_val(cfg.target0_control, want.target0_control, "target0");
            chk_val(cfg.target1_control, want.target1_control, "target1");
            chk_val(cfg.local_slave0_control, want.local_slave0_control, "slave ctl");
            chk_val(cfg.local_slave0_translation, want.local_slave0_translation, "at");
            chk_val(cfg.ident_reg, want.ident_reg, "ident");
            chk_val(32'(cfg.class_code), 32'(want.class_code), "class");
            chk_val(32'(cfg.latency_limit), 32'(want.latency_limit), "latency");
            apb(1'b0, OFS_MISC, 32'h0);
            chk_val(32'(rd[31:24]), 32'(want.latency_limit), "misc read");
            apb(1'b0, OFS_STATUS, 32'h0);
            chk_val(32'(rd[3:0]), 32'({sel_tab[k] == 3'h2, 3'h2}), "status");
            wv = $urandom;
            apb(1'b1, OFS_SUBSYS, wv);
            apb(1'b0, OFS_SUBSYS, 32'h0);
            chk_val(rd, wv, "write after load");
            $display("test %0d done", k);
        end
        test_done();
    end
endmodule

// file: test/srm_loader_properties.sv
module srm_loader_properties
    import srm_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // APB side
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Host and serial side
    input wire logic              host_rst_n,
    input wire logic              host_retry,
    input wire srm_cfg_t          cfg,
    input wire logic              scl_out,
    input wire logic              sda_in,
    input wire logic              sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_cfg_read;
        $past(host_retry) && psel && penable && !pwrite && paddr <= 8'h20 &&
            paddr[1:0] == 2'h0;
    endsequence
    sequence s_host_start;
        $rose(host_rst_n) && sda_in;
    endsequence
    chk_access_ready: assert property (psel && penable |-> pready)
        else $error("access without ready");
    // Write data never reaches prdata, so only reads must show zero
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h28 |->
        pslverr && (pwrite || prdata == 0))
        else $error("unmapped access not flagged");
    chk_mapped_ok: assert property (psel && penable && paddr <= 8'h28 && paddr[1:0] == 2'h0 |->
        !pslverr)
        else $error("mapped access flagged");
    chk_load_reads_zero: assert property (s_cfg_read |-> prdata == 32'h0 && !pslverr)
        else $error("read during load not zero");
    chk_cfg_cause: assert property ($changed(cfg) |-> $past(host_retry || psel && penable && pwrite))
        else $error("fields changed without cause");
    chk_idle_lines: assert property (!host_retry && !$past(host_retry) |-> scl_out && !sda_oe)
        else $error("serial lines busy outside load");
    chk_load_starts: assert property (s_host_start |-> ##[1:8] host_retry)
        else $error("load did not start");
    chk_reset_quiet: assert property (!host_rst_n [*6] |-> !host_retry)
        else $error("loading during host reset");
    // Host reset may cut a frame anywhere, so only a finished load is held to this
    chk_load_ends_stop: assert property ($fell(host_retry) && host_rst_n |->
        scl_out && $past(scl_out))
        else $error("load ended with clock low");
endmodule

bind srm_loader srm_loader_properties #(.ADDR_W(ADDR_W)) u_props (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_rst_n(host_rst_n), .host_retry(host_retry), .cfg(cfg), .scl_out(scl_out),
    .sda_in(sda_in), .sda_oe(sda_oe)
);
